// ==== rtl/gpio_line_pkg.sv ====
package gpio_line_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_LINES = 4;
  localparam int NUM_USER = 4;
  localparam int NUM_KINDS = 2;
  localparam int SRC_W = 5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_US = 1;
  localparam int CYC_PER_US = (TICK_US * 1000) / CLK_PERIOD_NS;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_LINE_SEL = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_RAIL = 8'h08;
  localparam logic [7:0] OFF_INVERT = 8'h0C;
  localparam logic [7:0] OFF_LEVEL = 8'h10;
  localparam logic [7:0] OFF_ALL_LEVELS = 8'h14;
  localparam logic [7:0] OFF_KIND_SEL = 8'h18;
  localparam logic [7:0] OFF_WIDTH_US = 8'h1C;
  localparam logic [7:0] OFF_SRC_SEL = 8'h20;
  localparam logic [7:0] OFF_CIRCUIT = 8'h24;
  localparam logic [7:0] OFF_USER_IDX = 8'h28;
  localparam logic [7:0] OFF_USER_LVL = 8'h2C;
  localparam logic [7:0] OFF_USER_ALL = 8'h30;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RST_WIDTH_US = 32'h0000_0000;
  localparam logic [3:0] RST_LINES = 4'h0;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [SRC_W-1:0] {
    SRC_OFF = 5'h00,
    SRC_LINE0 = 5'h01,
    SRC_LINE1 = 5'h02,
    SRC_LINE2 = 5'h03,
    SRC_LINE3 = 5'h04,
    SRC_USER0 = 5'h05,
    SRC_USER1 = 5'h06,
    SRC_USER2 = 5'h07,
    SRC_USER3 = 5'h08,
    SRC_CNT0 = 5'h09,
    SRC_CNT1 = 5'h0A,
    SRC_LOGIC0 = 5'h0B,
    SRC_LOGIC1 = 5'h0C,
    SRC_EXPOSING = 5'h0D,
    SRC_TRIG_WAIT = 5'h0E
  } line_src_t;

  localparam logic KIND_DEGLITCH = 1'b0;
  localparam logic KIND_DEBOUNCE = 1'b1;

  localparam logic [2:0] FMT_TRI_STATE = 3'h1;
  localparam logic [2:0] FMT_OPTO = 3'h5;
  localparam logic [2:0] FMT_OPEN_DRAIN = 3'h6;

endpackage : gpio_line_pkg

// ==== rtl/general_purpose_line_control.sv ====
`timescale 1ns/1ps
`default_nettype none

module general_purpose_line_control
  import gpio_line_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal source signals
  input wire logic [1:0] counter_active,
  input wire logic [1:0] logic_block_out,
  input wire logic exposing,
  input wire logic trigger_wait,
  // Connector lines
  input wire logic [3:0] line_in,
  output logic [3:0] line_out,
  output logic [3:0] line_oe,
  output logic [3:0] rail_enable
);

  // ****************************************************************
  // Configuration state
  // ****************************************************************
  logic [1:0] line_sel_q;
  logic kind_sel_q;
  logic [1:0] user_idx_q;
  logic [3:0] dir_q;
  logic [3:0] inv_q;
  logic [3:0] rail_q;
  logic [3:0] user_q;
  logic [SRC_W-1:0] src_q [NUM_LINES];
  logic [31:0] width_q [NUM_LINES][NUM_KINDS];
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [3:0] out_q;
  logic [3:0] status_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] dg_q;
  logic [3:0] db_q;
  logic [31:0] gcnt_q [NUM_LINES];
  logic [31:0] bcnt_q [NUM_LINES];
  logic [5:0] tick_cnt_q;
  logic tick;

  logic setup;
  logic wr;
  logic mapped;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && ce;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  function automatic logic [2:0] circuit_of(input logic [1:0] idx);
    if (idx == 2'd0 || idx == 2'd1) begin
      circuit_of = FMT_OPTO;
    end else if (idx == 2'd2) begin
      circuit_of = FMT_OPEN_DRAIN;
    end else begin
      circuit_of = FMT_TRI_STATE;
    end
  endfunction : circuit_of

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= OFF_USER_ALL) && (a[1:0] == 2'b00);
  endfunction : is_mapped

  assign mapped = is_mapped(paddr);

  function automatic logic src_pick(input logic [SRC_W-1:0] s,
                                    input logic [3:0] lines,
                                    input logic [3:0] users,
                                    input logic [1:0] cnt,
                                    input logic [1:0] lb,
                                    input logic expo,
                                    input logic twait);
    src_pick = 1'b0;
    case (s)
      SRC_LINE0: src_pick = lines[0];
      SRC_LINE1: src_pick = lines[1];
      SRC_LINE2: src_pick = lines[2];
      SRC_LINE3: src_pick = lines[3];
      SRC_USER0: src_pick = users[0];
      SRC_USER1: src_pick = users[1];
      SRC_USER2: src_pick = users[2];
      SRC_USER3: src_pick = users[3];
      SRC_CNT0: src_pick = cnt[0];
      SRC_CNT1: src_pick = cnt[1];
      SRC_LOGIC0: src_pick = lb[0];
      SRC_LOGIC1: src_pick = lb[1];
      SRC_EXPOSING: src_pick = expo;
      SRC_TRIG_WAIT: src_pick = twait;
      default: src_pick = 1'b0;
    endcase
  endfunction : src_pick

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // per-line indexed settings
  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_sel_q <= 2'h0;
      kind_sel_q <= KIND_DEGLITCH;
      user_idx_q <= 2'h0;
      dir_q <= RST_LINES;
      inv_q <= RST_LINES;
      rail_q <= RST_LINES;
      for (int i = 0; i < NUM_LINES; i++) begin
        src_q[i] <= SRC_OFF;
        for (int k = 0; k < NUM_KINDS; k++) begin
          width_q[i][k] <= RST_WIDTH_US;
        end
      end
    end else if (wr) begin
      if (paddr == OFF_LINE_SEL) begin
        line_sel_q <= pwdata[1:0];
      end else if (paddr == OFF_DIR) begin
        dir_q[line_sel_q] <= pwdata[0];
      end else if (paddr == OFF_RAIL) begin
        rail_q[line_sel_q] <= pwdata[0];
      end else if (paddr == OFF_INVERT) begin
        inv_q[line_sel_q] <= pwdata[0];
      end else if (paddr == OFF_KIND_SEL) begin
        kind_sel_q <= pwdata[0];
      end else if (paddr == OFF_WIDTH_US) begin
        width_q[line_sel_q][kind_sel_q] <= pwdata;
      end else if (paddr == OFF_SRC_SEL) begin
        src_q[line_sel_q] <= pwdata[SRC_W-1:0];
      end else if (paddr == OFF_USER_IDX) begin
        user_idx_q <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      user_q <= RST_LINES;
    end else if (wr) begin
      if (paddr == OFF_USER_LVL) begin
        user_q[user_idx_q] <= pwdata[0];
      end else if (paddr == OFF_USER_ALL) begin
        user_q <= pwdata[3:0];
      end
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Read data is captured in the setup cycle and shown in the access.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce && setup) begin
      pslverr_q <= !mapped;
      prdata_q <= 32'h0000_0000;
      if (paddr == OFF_LINE_SEL) begin
        prdata_q[1:0] <= line_sel_q;
      end else if (paddr == OFF_DIR) begin
        prdata_q[0] <= dir_q[line_sel_q];
      end else if (paddr == OFF_RAIL) begin
        prdata_q[0] <= rail_q[line_sel_q];
      end else if (paddr == OFF_INVERT) begin
        prdata_q[0] <= inv_q[line_sel_q];
      end else if (paddr == OFF_LEVEL) begin
        prdata_q[0] <= status_q[line_sel_q];
      end else if (paddr == OFF_ALL_LEVELS) begin
        prdata_q[3:0] <= status_q;
      end else if (paddr == OFF_KIND_SEL) begin
        prdata_q[0] <= kind_sel_q;
      end else if (paddr == OFF_WIDTH_US) begin
        prdata_q <= width_q[line_sel_q][kind_sel_q];
      end else if (paddr == OFF_SRC_SEL) begin
        prdata_q[SRC_W-1:0] <= src_q[line_sel_q];
      end else if (paddr == OFF_CIRCUIT) begin
        prdata_q[2:0] <= circuit_of(line_sel_q);
      end else if (paddr == OFF_USER_IDX) begin
        prdata_q[1:0] <= user_idx_q;
      end else if (paddr == OFF_USER_LVL) begin
        prdata_q[0] <= user_q[user_idx_q];
      end else if (paddr == OFF_USER_ALL) begin
        prdata_q[3:0] <= user_q;
      end
    end
  end

  // ****************************************************************
  // Microsecond tick and synchroniser
  // ****************************************************************
  // microsecond tick
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick_cnt_q <= 6'h00;
    end else if (ce) begin
      tick_cnt_q <= tick ? 6'h00 : tick_cnt_q + 6'h01;
    end
  end
  assign tick = (tick_cnt_q == 6'(CYC_PER_US - 1));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_q <= RST_LINES;
      sync2_q <= RST_LINES;
    end else if (ce) begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************************************
  // Per-line filters and drivers
  // ****************************************************************
  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    always_ff @(posedge clk) begin
      if (!rstn) begin
        dg_q[g] <= 1'b0;
        gcnt_q[g] <= 32'h0000_0000;
      end else if (ce) begin
        if (sync2_q[g] == dg_q[g]) begin
          gcnt_q[g] <= 32'h0000_0000;
        // A tick may follow at once, so one tick beyond the width is needed.
        end else if (width_q[g][KIND_DEGLITCH] == 32'h0 ||
                     gcnt_q[g] > width_q[g][KIND_DEGLITCH]) begin
          dg_q[g] <= sync2_q[g];
          gcnt_q[g] <= 32'h0000_0000;
        end else if (tick) begin
          gcnt_q[g] <= gcnt_q[g] + 32'h0000_0001;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rstn) begin
        db_q[g] <= 1'b0;
        bcnt_q[g] <= 32'h0000_0000;
      end else if (ce) begin
        if (bcnt_q[g] != 32'h0000_0000) begin
          if (tick) begin
            bcnt_q[g] <= bcnt_q[g] - 32'h0000_0001;
          end
        end else if (dg_q[g] != db_q[g]) begin
          db_q[g] <= dg_q[g];
          // One extra tick keeps the block for at least the full width.
          bcnt_q[g] <= width_q[g][KIND_DEBOUNCE] + {31'h0,
                       |width_q[g][KIND_DEBOUNCE] &&
                       !(&width_q[g][KIND_DEBOUNCE])};
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rstn) begin
        out_q[g] <= 1'b0;
        status_q[g] <= 1'b0;
      end else if (ce) begin
        out_q[g] <= src_pick(src_q[g], status_q, user_q, counter_active,
                             logic_block_out, exposing, trigger_wait)
                    ^ inv_q[g];
        status_q[g] <= dir_q[g] ? out_q[g] : (db_q[g] ^ inv_q[g]);
      end
    end
  end

  assign line_oe = dir_q;
  assign line_out = out_q;
  assign rail_enable = rail_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  oe_dir_a: assert property (line_oe == dir_q)
    else $error("line driven while not an output");

  out_user_a: assert property (
    ce && src_q[3] == SRC_USER0 |=>
      line_out[3] == ($past(user_q[0]) ^ $past(inv_q[3])))
    else $error("user source not driven with inversion");

  all_levels_a: assert property (
    ce && setup && paddr == OFF_ALL_LEVELS |=>
      prdata[3:0] == $past(status_q) && prdata[31:4] == 28'h0)
    else $error("packed line levels read wrong");

  user_all_a: assert property (
    wr && paddr == OFF_USER_ALL |=> user_q == $past(pwdata[3:0]))
    else $error("packed user write lost");

  user_one_a: assert property (
    wr && paddr == OFF_USER_LVL |=>
      user_q[$past(user_idx_q)] == $past(pwdata[0]))
    else $error("indexed user write lost");

  deglitch_hold_a: assert property (
    dg_q[0] != $past(dg_q[0]) |->
      $past(width_q[0][KIND_DEGLITCH]) == 32'h0 ||
      $past(gcnt_q[0]) > $past(width_q[0][KIND_DEGLITCH]))
    else $error("deglitch accepted before width");

  debounce_block_a: assert property (
    db_q[0] != $past(db_q[0]) |-> $past(bcnt_q[0]) == 32'h0)
    else $error("debounce changed while blocked");

  debounce_pass_a: assert property (
    ce && bcnt_q[0] == 32'h0 && dg_q[0] != db_q[0] |=>
      db_q[0] == $past(dg_q[0]))
    else $error("debounce did not pass first edge");

  drive_out_c: cover property (ce && line_oe[1] && line_out[1]);
  deglitch_c: cover property (dg_q[0] != $past(dg_q[0]));
  debounce_c: cover property (bcnt_q[0] != 32'h0 && dg_q[0] != db_q[0]);

endmodule : general_purpose_line_control

`default_nettype wire

// ==== verification/line_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// External circuits wired to the connector lines
// ********************************************************
module line_partner (
  // Device side of the pins
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe,
  // Levels applied by the outside circuits
  input wire logic [3:0] ext_level,
  // Wire levels seen back by the device
  output logic [3:0] line_in
);
  // A driven line carries the device level, an idle one the outside level.
  always_comb line_in = (line_oe & line_out) | (~line_oe & ext_level);
endmodule : line_partner

`default_nettype wire

// ==== verification/general_purpose_line_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module general_purpose_line_control_tb;
  import gpio_line_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [1:0] cnt = 2'h0;
  logic [1:0] lb = 2'h0;
  logic expo = 1'b0;
  logic twait = 1'b0;
  logic [3:0] ext = 4'h0;
  logic [3:0] lin, lout, loe, rail, m_user, m_exp;
  int failures = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  general_purpose_line_control DUT (
    .clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_active(cnt),
    .logic_block_out(lb), .exposing(expo), .trigger_wait(twait),
    .line_in(lin), .line_out(lout), .line_oe(loe), .rail_enable(rail));

  line_partner ext_ckt (.line_out(lout), .line_oe(loe), .ext_level(ext),
    .line_in(lin));

  // ********************************************************
  // Bus, compare and model helpers
  // ********************************************************
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      failures++;
      complete_run();
    end
  endtask : apb

  task automatic chk_rd(input string nm, input logic [31:0] e);
    n_checks++;
    if (rd !== e) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, rd);
    end
  endtask : chk_rd

  task automatic chk_pin(input string nm, input logic [3:0] e,
                         input logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk_pin

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_rd(nm, e);
  endtask : rdc

  task automatic lvl(input int k, input logic e);
    wr(OFF_LINE_SEL, k);
    rdc("level", OFF_LEVEL, {31'h0, e});
  endtask : lvl

  function automatic logic drive(input int s, input logic inv);
    logic v;
    v = 1'b0;
    if (s inside {[5:8]}) v = m_user[s-5];
    if (s inside {[9:10]}) v = cnt[s-9];
    if (s inside {[11:12]}) v = lb[s-11];
    if (s == 13) v = expo;
    if (s == 14) v = twait;
    return v ^ inv;
  endfunction : drive

  // ********************************************************
  // Scenarios
  // ********************************************************
  initial begin
    void'($urandom(32'hF399));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(OFF_LINE_SEL, k);
      rdc("dir", OFF_DIR, 32'h0);
      rdc("width", OFF_WIDTH_US, RST_WIDTH_US);
      rdc("circuit", OFF_CIRCUIT, k < 2 ? FMT_OPTO :
          (k == 2 ? FMT_OPEN_DRAIN : FMT_TRI_STATE));
    end
    apb(1'b0, 8'h34, 32'h0);
    chk_rd("unmapped", 32'h0);
    chk_pin("slverr", 4'h1, {3'h0, er});
    wr(OFF_LINE_SEL, 2);
    wr(OFF_RAIL, 1);
    repeat (2) @(posedge clk);
    chk_pin("rail", 4'h4, rail);
    $display("test reset done");
    wr(OFF_LINE_SEL, 3);
    wr(OFF_DIR, 1);
    repeat (2) @(posedge clk);
    chk_pin("oe", 4'h8, loe);
    for (int s = 0; s < 15; s++) begin
      if (s inside {[1:4]}) continue;
      m_user = 4'($urandom);
      cnt <= 2'($urandom);
      lb <= 2'($urandom);
      expo <= 1'($urandom);
      twait <= 1'($urandom);
      wr(OFF_USER_ALL, m_user);
      rdc("user_all", OFF_USER_ALL, m_user);
      wr(OFF_SRC_SEL, s);
      wr(OFF_INVERT, s % 2);
      repeat (3) @(posedge clk);
      chk_pin("drive", drive(s, s % 2), lout[3]);
    end
    wr(OFF_USER_IDX, 1);
    wr(OFF_USER_LVL, ~m_user[1]);
    m_user[1] = ~m_user[1];
    rdc("user_all", OFF_USER_ALL, m_user);
    $display("test sources done");
    wr(OFF_SRC_SEL, SRC_LINE1);
    wr(OFF_INVERT, 0);
    wr(OFF_LINE_SEL, 2);
    wr(OFF_INVERT, 1);
    for (int r = 0; r < 4; r++) begin
      ext <= 4'($urandom);
      repeat (20) @(posedge clk);
      m_exp = {ext[1], ~ext[2], ext[1:0]};
      chk_pin("loop", ext[1], lout[3]);
      rdc("all_levels", OFF_ALL_LEVELS, m_exp);
      for (int k = 0; k < 4; k++) lvl(k, m_exp[k]);
    end
    $display("test levels done");
    wr(OFF_LINE_SEL, 0);
    wr(OFF_KIND_SEL, KIND_DEGLITCH);
    wr(OFF_WIDTH_US, 2);
    wr(OFF_LINE_SEL, 1);
    wr(OFF_KIND_SEL, KIND_DEBOUNCE);
    wr(OFF_WIDTH_US, 3);
    wr(OFF_KIND_SEL, KIND_DEGLITCH);
    rdc("width", OFF_WIDTH_US, 32'h0);
    wr(OFF_KIND_SEL, KIND_DEBOUNCE);
    rdc("width", OFF_WIDTH_US, 32'h3);
    ext <= 4'h0;
    repeat (300) @(posedge clk);
    ext <= 4'h1;
    repeat (40) @(posedge clk);
    ext <= 4'h0;
    repeat (200) @(posedge clk);
    lvl(0, 1'b0);
    ext <= 4'h1;
    repeat (60) @(posedge clk);
    lvl(0, 1'b0);
    repeat (150) @(posedge clk);
    lvl(0, 1'b1);
    $display("test deglitch done");
    ext <= 4'h3;
    repeat (10) @(posedge clk);
    lvl(1, 1'b1);
    ext <= 4'h1;
    repeat (60) @(posedge clk);
    lvl(1, 1'b1);
    repeat (200) @(posedge clk);
    lvl(1, 1'b0);
    $display("test debounce done");
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_pin("oe_reset", 4'h0, loe);
    wr(OFF_LINE_SEL, 1);
    wr(OFF_KIND_SEL, KIND_DEBOUNCE);
    rdc("width_reset", OFF_WIDTH_US, RST_WIDTH_US);
    ce <= 1'b0;
    wr(OFF_USER_ALL, 32'hF);
    ce <= 1'b1;
    rdc("ce_hold", OFF_USER_ALL, 32'h0);
    $display("test reset and enable done");
    complete_run();
  end
endmodule : general_purpose_line_control_tb

`default_nettype wire
